/* File: testbench.sv */
// self-checking bench for the mission logging engine
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import tlh_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, alarm_search_hit;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rs = 32'h13;
  logic sample_valid, mission_active;
  logic [7:0] sample_code;
  logic [7:0] lg[LOG_DEPTH];
  logic [33:0] rq[$], bq[$];
  logic on = 1'b0, wrap = 1'b0;
  int n_fail = 0, tests_run = 0, cyc = 0, life = 0, mcnt = 0;
  int hist[64];
  int s0, s1;
  tlh_logger tlh_logger_i (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .sample_valid,
    .sample_code, .mission_active, .alarm_search_hit);
  tlh_sensor_model model_i (.aclk, .aresetn, .sample_valid, .sample_code,
    .mission_active);
  always #20 aclk = ~aclk;
  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  task automatic chk(input string nm, input logic [33:0] e,
                     input logic [33:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  task automatic tend(input string s);
    $display("test %s done, mismatches so far %0d", s, n_fail);
  endtask : tend
  task automatic wr(input logic [12:0] i, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] e);
    logic a, w, da, dw;
    bq.push_back({32'h0, e});
    da = 1'b0;
    dw = 1'b0;
    @(posedge aclk);
    awaddr <= {i, 2'b00};
    wdata <= {xs(rs) & 32'hFFFF_FF00} | {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(da && dw)) begin
      @(negedge aclk);
      a = !da && awready === 1'b1;
      w = !dw && wready === 1'b1;
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      da |= a;
      dw |= w;
    end
    while (bvalid !== 1'b1) @(negedge aclk);
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [12:0] i, input logic [7:0] d,
                    input logic [1:0] e);
    rq.push_back({e, 24'h0, d});
    @(posedge aclk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(negedge aclk);
    while (arready !== 1'b1) @(negedge aclk);
    @(posedge aclk);
    arvalid <= 1'b0;
    @(negedge aclk);
    while (rvalid !== 1'b1) @(negedge aclk);
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rd
  task automatic rbin(input int b);
    rd(IDX_HIST_BASE + 13'(2 * b), 8'(hist[b]), RESP_OKAY);
    rd(IDX_HIST_BASE + 13'(2 * b + 1), 8'(hist[b] >> 8), RESP_OKAY);
  endtask : rbin
  task automatic rslot(input logic [12:0] base, input int s, input int c,
                       input int dur);
    for (int k = 0; k < 3; k++) rd(base + 13'(4 * s + k), 8'(c >> 8 * k),
                                   RESP_OKAY);
    rd(base + 13'(4 * s + 3), 8'(dur), RESP_OKAY);
  endtask : rslot
  // expected log and bins follow every mission result handed to the model
  task automatic smp(input int t, input int n);
    int c;
    c = t < 0 ? 0 : (t > 255 ? 255 : t);
    for (int k = 0; k < n; k++) begin
      model_i.put(t);
      if (on && (wrap || mcnt < LOG_DEPTH)) lg[mcnt % LOG_DEPTH] = 8'(c);
      if (on) mcnt++;
    end
    life += n;
    if (on) hist[c / 4] = hist[c / 4] + n > 65535 ? 65535 : hist[c / 4] + n;
    while (model_i.q.size() != 0) @(posedge aclk);
    repeat (6) @(posedge aclk);
  endtask : smp
  task automatic mis(input logic m);
    model_i.mission(m);
    on = m;
    mcnt = 0;
    repeat (2) @(posedge aclk);
  endtask : mis
  task automatic hit(input logic e);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("search_hit", {33'h0, e}, {33'h0, alarm_search_hit});
    @(posedge aclk);
  endtask : hit
  // ************************************************************
  // response monitor and watchdog
  // ************************************************************
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready) chk("rdata", rq.pop_front(),
                                         {rresp, rdata});
    if (bvalid === 1'b1 && bready) chk("bresp", bq.pop_front(),
                                         {32'h0, bresp});
  end
  // longest run is the saturation fill, about 65536 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      n_fail++;
      conclude();
    end
  end
  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IDX_THR_LOW, THR_LOW_RST, RESP_OKAY);
    rd(IDX_THR_HIGH, THR_HIGH_RST, RESP_OKAY);
    rd(IDX_CTRL, CTRL_RST, RESP_OKAY);
    rd(IDX_STATUS, 8'h00, RESP_OKAY);
    rd(13'h0100, 8'h00, RESP_SLVERR);
    wr(IDX_LIFE_LO, 8'h5A, 4'hF, RESP_SLVERR);
    wr(IDX_THR_LOW, 8'h33, 4'hE, RESP_OKAY);
    rd(IDX_THR_LOW, THR_LOW_RST, RESP_OKAY);
    tend("reset");
    smp(8'h80, 3);
    rbin(32);
    rd(IDX_LIFE_LO, 8'(life), RESP_OKAY);
    tend("idle");
    wr(IDX_THR_LOW, 8'h40, 4'h1, RESP_OKAY);
    wr(IDX_THR_HIGH, 8'hC0, 4'h1, RESP_OKAY);
    mis(1'b1);
    for (int k = 0; k < 10; k++) begin
      rs = xs(rs);
      smp(32'h41 + int'(rs % 32'h7F), 1);
    end
    rd(IDX_STATUS, 8'h20, RESP_OKAY);
    for (int k = 0; k < 10; k++) begin
      rd(IDX_LOG_BASE + 13'(k), lg[k], RESP_OKAY);
      rbin(int'(lg[k][7:2]));
    end
    smp(8'h40, 1);
    s0 = mcnt;
    smp(-20, 2);
    smp(8'h80, 1);
    smp(8'h3F, 1);
    rslot(IDX_ALARM_BASE, 0, s0, 3);
    rslot(IDX_ALARM_BASE, 1, mcnt, 1);
    rbin(0);
    rd(IDX_STATUS, 8'h24, RESP_OKAY);
    hit(1'b0);
    wr(IDX_CTRL, 8'h02, 4'h1, RESP_OKAY);
    hit(1'b1);
    wr(IDX_STATUS, 8'h00, 4'h1, RESP_OKAY);
    hit(1'b0);
    smp(300, 1);
    s1 = mcnt;
    rslot(IDX_ALARM_BASE + 13'h30, 0, s1, 1);
    rbin(63);
    rd(IDX_STATUS, 8'h22, RESP_OKAY);
    tend("alarm");
    smp(8'h10, 256);
    rslot(IDX_ALARM_BASE, 2, mcnt - 255, 255);
    rslot(IDX_ALARM_BASE, 3, mcnt, 1);
    for (int k = 4; k < 13; k++) begin
      smp(8'h80, 1);
      smp(8'h10, 1);
      if (k == 11) s0 = mcnt;
    end
    rslot(IDX_ALARM_BASE, 11, s0, 1);
    rslot(IDX_ALARM_BASE + 13'h30, 1, 0, 0);
    rd(IDX_STATUS, 8'h26, RESP_OKAY);
    tend("slots");
    smp(8'h80, LOG_DEPTH + 1 - mcnt);
    rd(IDX_LOG_BASE, lg[0], RESP_OKAY);
    rd(IDX_LOG_END, lg[LOG_DEPTH - 1], RESP_OKAY);
    rbin(32);
    rd(IDX_LIFE_MID, 8'(life >> 8), RESP_OKAY);
    tend("fill");
    mis(1'b0);
    wr(IDX_CTRL, 8'h12, 4'h1, RESP_OKAY);
    wrap = 1'b1;
    mis(1'b1);
    smp(8'h44, 1);
    model_i.slow = 1'b1;
    smp(8'h90, LOG_DEPTH - 1);
    model_i.slow = 1'b0;
    smp(8'hA0, 1);
    rd(IDX_LOG_BASE, lg[0], RESP_OKAY);
    rd(IDX_LOG_BASE + 13'h1, lg[1], RESP_OKAY);
    smp(8'h70, 65536);
    rbin(28);
    rd(IDX_LIFE_HI, 8'(life >> 16), RESP_OKAY);
    tend("wrap");
    conclude();
  end
endmodule : testbench
`default_nettype wire

/* File: tlh_logger.sv */
// mission logging engine: datalog, histogram, alarm stamps, axi4-lite
// Functional notes
// - each mission sample goes to the histogram, and to the log unless it is full
// - first mission sample at log index 1000h, then ascending
// - log holds 2048 one-byte samples
// - wrap off: keep first 2048, stop logging, histogram/alarms go on
// - wrap on: sample 2049 back at 1000h, log keeps latest 2048
// - 64 bins of 16 bits at 0800h, low byte at lower index
// - bins count mission samples only
// - bin index is the code with its two low bits dropped
// - out of range codes arrive clamped and land in end bins
// - bins saturate at 65535
// - low and high limits live at 20Bh and 20Ch
// - no alarm while low < code < high
// - code at or past a limit sets the low or high flag at 214h
// - search enable at 20Eh makes a set flag answer search
// - entering an excursion stamps time, then counts duration
// - stamps live at 0220h..027Fh, 12 low then 12 high slots
// - stamp is 3-byte mission count lsb first, then duration
// - duration at 255 or a new excursion opens the next slot
// - lifetime 24-bit count of all samples, not resettable by software
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module tlh_logger (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [tlh_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [tlh_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic sample_valid,
  input wire logic [7:0] sample_code,
  input wire logic mission_active,
  output logic alarm_search_hit
);
  import tlh_pkg::*;

  // ************************************************************
  // storage and state
  // ************************************************************
  logic [7:0] datalog_mem [LOG_DEPTH];
  logic [15:0] hist_ff [HIST_BINS];
  logic [7:0] alarm_mem [2*ALARM_SLOTS*SLOT_BYTES];
  logic [7:0] thr_low_ff, thr_high_ff, ctrl_ff;
  logic lower_band_flag_ff, upper_band_flag_ff;
  logic mission_prev_ff, alarm_search_hit_ff;
  logic [23:0] mission_cnt_ff, life_cnt_ff;
  logic [10:0] log_ptr_ff;
  logic log_full_ff;
  logic in_alarm_ff [2];
  logic [3:0] slot_ff [2];
  logic [7:0] dur_ff [2];
  tlh_wr_st_t ws_ff;
  logic aw_got_ff, w_got_ff;
  logic [12:0] aw_idx_ff;
  logic [7:0] w_byte_ff;
  logic w_lane_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff, bresp_ff;
  logic rvalid_ff;

  function automatic logic [6:0] alarm_byte(input logic dir,
      input logic [3:0] slot, input logic [1:0] k);
    alarm_byte = 7'(({3'b000, dir} * 48) + (slot * 4) + k);
  endfunction : alarm_byte

  // ************************************************************
  // sample path decisions
  // ************************************************************
  logic mission_start, run, wrap_en;
  logic [5:0] bin;
  logic [23:0] nxt_mission_cnt;
  logic [10:0] ptr_base, nxt_log_ptr;
  logic full_base, nxt_log_full, log_write;
  logic exc [2];
  logic in_base [2], rec [2], cont [2], nxt_in_alarm [2];
  logic [3:0] slot_base [2], nxt_slot [2];
  logic [7:0] nxt_dur [2];

  assign mission_start = mission_active & ~mission_prev_ff;
  assign run = sample_valid & mission_active;
  assign wrap_en = ctrl_ff[CTRL_WRAP_BIT];
  // clamping is done by the conversion core; 00h/FFh fall in bins 0/63
  assign bin = sample_code[7:2];
  assign exc[0] = sample_code <= thr_low_ff;
  assign exc[1] = sample_code >= thr_high_ff;

  always_comb begin
    nxt_mission_cnt = (mission_start ? 24'h000000 : mission_cnt_ff) + 24'h1;
    ptr_base = mission_start ? 11'h000 : log_ptr_ff;
    full_base = mission_start ? 1'b0 : log_full_ff;
    log_write = run & ~full_base;
    nxt_log_ptr = log_write ? ptr_base + 11'h001 : ptr_base;
    nxt_log_full = full_base |
                   (log_write & (ptr_base == 11'h7FF) & ~wrap_en);
    for (int d = 0; d < 2; d++) begin
      in_base[d] = mission_start ? 1'b0 : in_alarm_ff[d];
      slot_base[d] = mission_start ? 4'h0 : slot_ff[d];
      rec[d] = run & exc[d] & (~in_base[d] | dur_ff[d] == DUR_MAX) &
               (slot_base[d] < 4'(ALARM_SLOTS));
      cont[d] = run & exc[d] & in_base[d] & (dur_ff[d] != DUR_MAX);
      nxt_in_alarm[d] = run ? (rec[d] | cont[d]) : in_base[d];
      nxt_slot[d] = rec[d] ? slot_base[d] + 4'h1 : slot_base[d];
      nxt_dur[d] = rec[d] ? 8'h01 : (cont[d] ? dur_ff[d] + 8'h01 : dur_ff[d]);
    end
  end

  // ************************************************************
  // mission and lifetime counters
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mission_prev_ff <= 1'b0;
      mission_cnt_ff <= 24'h000000;
    end else begin
      mission_prev_ff <= mission_active;
      if (run) begin
        mission_cnt_ff <= nxt_mission_cnt;
      end else if (mission_start) begin
        mission_cnt_ff <= 24'h000000;
      end
    end
  end

  // only a hardware reset clears it; no bus write reaches it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      life_cnt_ff <= 24'h000000;
    end else if (sample_valid) begin
      life_cnt_ff <= life_cnt_ff + 24'h1;
    end
  end

  // ************************************************************
  // datalog
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      log_ptr_ff <= 11'h000;
      log_full_ff <= 1'b0;
    end else if (run || mission_start) begin
      log_ptr_ff <= nxt_log_ptr;
      log_full_ff <= nxt_log_full;
    end
  end

  // large array, no reset: contents are undefined until written
  always_ff @(posedge aclk) begin
    if (log_write) begin
      datalog_mem[ptr_base] <= sample_code;
    end
  end

  // ************************************************************
  // histogram
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < HIST_BINS; i++) begin
        hist_ff[i] <= 16'h0000;
      end
    end else if (run && hist_ff[bin] != BIN_MAX) begin
      hist_ff[bin] <= hist_ff[bin] + 16'h0001;
    end
  end

  // ************************************************************
  // alarm stamps and durations
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int d = 0; d < 2; d++) begin
        in_alarm_ff[d] <= 1'b0;
        slot_ff[d] <= 4'h0;
        dur_ff[d] <= 8'h00;
      end
    end else begin
      for (int d = 0; d < 2; d++) begin
        in_alarm_ff[d] <= nxt_in_alarm[d];
        slot_ff[d] <= nxt_slot[d];
        dur_ff[d] <= nxt_dur[d];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 2*ALARM_SLOTS*SLOT_BYTES; i++) begin
        alarm_mem[i] <= 8'h00;
      end
    end else begin
      for (int d = 0; d < 2; d++) begin
        if (rec[d]) begin
          alarm_mem[alarm_byte(d[0], slot_base[d], 2'd0)] <=
            nxt_mission_cnt[7:0];
          alarm_mem[alarm_byte(d[0], slot_base[d], 2'd1)] <=
            nxt_mission_cnt[15:8];
          alarm_mem[alarm_byte(d[0], slot_base[d], 2'd2)] <=
            nxt_mission_cnt[23:16];
          alarm_mem[alarm_byte(d[0], slot_base[d], 2'd3)] <= 8'h01;
        end else if (cont[d]) begin
          alarm_mem[alarm_byte(d[0], slot_base[d] - 4'h1, 2'd3)] <=
            nxt_dur[d];
        end
      end
    end
  end

  // ************************************************************
  // axi4-lite write channel
  // ************************************************************
  logic do_write;
  assign awready = (ws_ff == WS_IDLE) & ~aw_got_ff;
  assign wready = (ws_ff == WS_IDLE) & ~w_got_ff;
  assign do_write = (ws_ff == WS_IDLE) & aw_got_ff & w_got_ff;
  assign bvalid = (ws_ff == WS_RESP);
  assign bresp = bresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ws_ff <= WS_IDLE;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_idx_ff <= 13'h0000;
      w_byte_ff <= 8'h00;
      w_lane_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      case (ws_ff)
        WS_IDLE: begin
          if (awvalid && awready) begin
            aw_got_ff <= 1'b1;
            aw_idx_ff <= awaddr[14:2];
          end
          if (wvalid && wready) begin
            w_got_ff <= 1'b1;
            w_byte_ff <= wdata[7:0];
            w_lane_ff <= wstrb[0];
          end
          if (do_write) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            ws_ff <= WS_RESP;
            if (aw_idx_ff == IDX_THR_LOW || aw_idx_ff == IDX_THR_HIGH ||
                aw_idx_ff == IDX_CTRL || aw_idx_ff == IDX_STATUS) begin
              bresp_ff <= RESP_OKAY;
            end else begin
              bresp_ff <= RESP_SLVERR;
            end
          end
        end
        WS_RESP: begin
          if (bready) begin
            ws_ff <= WS_IDLE;
          end
        end
        default: ws_ff <= WS_IDLE;
      endcase
    end
  end

  logic wr_en;
  assign wr_en = do_write & w_lane_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thr_low_ff <= THR_LOW_RST;
      thr_high_ff <= THR_HIGH_RST;
      ctrl_ff <= CTRL_RST;
    end else if (wr_en) begin
      if (aw_idx_ff == IDX_THR_LOW) begin
        thr_low_ff <= w_byte_ff;
      end else if (aw_idx_ff == IDX_THR_HIGH) begin
        thr_high_ff <= w_byte_ff;
      end else if (aw_idx_ff == IDX_CTRL) begin
        ctrl_ff <= w_byte_ff;
      end
    end
  end

  // flags: software clears by writing 0; a same-cycle alarm wins
  logic st_wr;
  assign st_wr = wr_en & (aw_idx_ff == IDX_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lower_band_flag_ff <= 1'b0;
      upper_band_flag_ff <= 1'b0;
    end else begin
      lower_band_flag_ff <= (run & exc[0]) | (lower_band_flag_ff &
        ~(st_wr & ~w_byte_ff[ST_LOW_BIT]));
      upper_band_flag_ff <= (run & exc[1]) | (upper_band_flag_ff &
        ~(st_wr & ~w_byte_ff[ST_HIGH_BIT]));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_search_hit_ff <= 1'b0;
    end else begin
      alarm_search_hit_ff <= ctrl_ff[CTRL_SEARCH_BIT] &
        (lower_band_flag_ff | upper_band_flag_ff);
    end
  end
  assign alarm_search_hit = alarm_search_hit_ff;

  // ************************************************************
  // axi4-lite read channel
  // ************************************************************
  logic [12:0] ar_idx;
  logic [7:0] rd_byte;
  logic rd_err;
  logic [12:0] rel;
  assign ar_idx = araddr[14:2];
  assign arready = ~rvalid_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  always_comb begin
    rd_byte = 8'h00;
    rd_err = 1'b0;
    rel = 13'h0000;
    if (ar_idx == IDX_THR_LOW) begin
      rd_byte = thr_low_ff;
    end else if (ar_idx == IDX_THR_HIGH) begin
      rd_byte = thr_high_ff;
    end else if (ar_idx == IDX_CTRL) begin
      rd_byte = ctrl_ff;
    end else if (ar_idx == IDX_STATUS) begin
      rd_byte[ST_LOW_BIT] = lower_band_flag_ff;
      rd_byte[ST_HIGH_BIT] = upper_band_flag_ff;
      rd_byte[ST_MISSION_BIT] = mission_prev_ff;
    end else if (ar_idx == IDX_LIFE_LO) begin
      rd_byte = life_cnt_ff[7:0];
    end else if (ar_idx == IDX_LIFE_MID) begin
      rd_byte = life_cnt_ff[15:8];
    end else if (ar_idx == IDX_LIFE_HI) begin
      rd_byte = life_cnt_ff[23:16];
    end else if (ar_idx >= IDX_ALARM_BASE && ar_idx <= IDX_ALARM_END) begin
      rel = ar_idx - IDX_ALARM_BASE;
      rd_byte = alarm_mem[rel[6:0]];
    end else if (ar_idx >= IDX_HIST_BASE && ar_idx <= IDX_HIST_END) begin
      rel = ar_idx - IDX_HIST_BASE;
      rd_byte = rel[0] ? hist_ff[rel[6:1]][15:8]
                       : hist_ff[rel[6:1]][7:0];
    end else if (ar_idx >= IDX_LOG_BASE && ar_idx <= IDX_LOG_END) begin
      rel = ar_idx - IDX_LOG_BASE;
      rd_byte = datalog_mem[rel[10:0]];
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h000000, rd_byte};
      rresp_ff <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  logic [5:0] last_bin_ff;
  logic [15:0] last_hist_ff;
  always_ff @(posedge aclk) begin
    last_bin_ff <= bin;
    last_hist_ff <= hist_ff[bin];
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_hist_step: assert property (run |=> hist_ff[last_bin_ff] ==
    ((last_hist_ff == BIN_MAX) ? BIN_MAX : last_hist_ff + 16'h0001))
    else $error("histogram bin did not step");
  chk_hist_saturate: assert property (
    (run && hist_ff[bin] == BIN_MAX) |=> hist_ff[last_bin_ff] == BIN_MAX)
    else $error("histogram bin left saturation");
  chk_hist_idle: assert property (
    !run |=> hist_ff[last_bin_ff] == last_hist_ff)
    else $error("histogram counted outside a mission");
  chk_log_first: assert property (
    (log_write && ptr_base == 11'h000) |=> log_ptr_ff == 11'h001 &&
    datalog_mem[0] == $past(sample_code))
    else $error("first sample not at log start");
  chk_log_stops: assert property (
    (run && log_full_ff && !mission_start) |=> $stable(log_ptr_ff) &&
    log_full_ff)
    else $error("log kept writing when full");
  chk_log_wraps: assert property (
    (run && wrap_en && !mission_start && log_ptr_ff == 11'h7FF)
    |=> log_ptr_ff == 11'h000 && !log_full_ff)
    else $error("log did not wrap");
  chk_low_flag: assert property (
    (run && sample_code <= thr_low_ff) |=> lower_band_flag_ff ##1
    (lower_band_flag_ff || $past(st_wr)))
    else $error("low flag not set");
  chk_band_quiet: assert property (
    (run && !mission_start && sample_code > thr_low_ff &&
     sample_code < thr_high_ff) |=> !in_alarm_ff[0] && !in_alarm_ff[1] &&
    $stable(slot_ff[0]) && $stable(slot_ff[1]))
    else $error("alarm recorded inside band");
  chk_life_count: assert property (
    sample_valid |=> life_cnt_ff == $past(life_cnt_ff) + 24'h1)
    else $error("lifetime count did not advance");
  chk_search_hit: assert property (
    (ctrl_ff[CTRL_SEARCH_BIT] && upper_band_flag_ff) |=> alarm_search_hit)
    else $error("search hit missing");

  cov_log_wrap: cover property (run && wrap_en && log_ptr_ff == 11'h7FF);
  cov_bin_sat: cover property (run && hist_ff[bin] == BIN_MAX);
  cov_alarm_open: cover property (rec[1] ##[1:100] rec[0]);
  cov_dur_split: cover property (rec[0] && in_base[0]);
endmodule : tlh_logger
`default_nettype wire

/* File: tlh_pkg.sv */
// shared constants for the temperature log, histogram and alarm engine
package tlh_pkg;
  // ************************************************************
  // register and memory word indices (byte address = 4 * index)
  // ************************************************************
  localparam int ADDR_W = 15;
  localparam logic [12:0] IDX_THR_LOW = 13'h020B;
  localparam logic [12:0] IDX_THR_HIGH = 13'h020C;
  localparam logic [12:0] IDX_CTRL = 13'h020E;
  localparam logic [12:0] IDX_STATUS = 13'h0214;
  localparam logic [12:0] IDX_LIFE_LO = 13'h021D;
  localparam logic [12:0] IDX_LIFE_MID = 13'h021E;
  localparam logic [12:0] IDX_LIFE_HI = 13'h021F;
  localparam logic [12:0] IDX_ALARM_BASE = 13'h0220;
  localparam logic [12:0] IDX_ALARM_END = 13'h027F;
  localparam logic [12:0] IDX_HIST_BASE = 13'h0800;
  localparam logic [12:0] IDX_HIST_END = 13'h087F;
  localparam logic [12:0] IDX_LOG_BASE = 13'h1000;
  localparam logic [12:0] IDX_LOG_END = 13'h17FF;
  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int ST_HIGH_BIT = 1;
  localparam int ST_LOW_BIT = 2;
  localparam int ST_MISSION_BIT = 5;
  localparam int CTRL_SEARCH_BIT = 1;
  localparam int CTRL_WRAP_BIT = 4;
  localparam logic [7:0] THR_LOW_RST = 8'h00;
  localparam logic [7:0] THR_HIGH_RST = 8'hFF;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // ************************************************************
  // sizes and limits
  // ************************************************************
  localparam int LOG_DEPTH = 2048;
  localparam int HIST_BINS = 64;
  localparam int ALARM_SLOTS = 12;
  localparam int SLOT_BYTES = 4;
  localparam logic [7:0] DUR_MAX = 8'hFF;
  localparam logic [15:0] BIN_MAX = 16'hFFFF;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic {WS_IDLE = 1'b0, WS_RESP = 1'b1} tlh_wr_st_t;
endpackage : tlh_pkg

/* File: tlh_sensor_model.sv */
// stand-in for the conversion core and mission sequencer
`timescale 1ns/10ps
`default_nettype none
module tlh_sensor_model (
  input wire logic aclk,
  input wire logic aresetn,
  output logic sample_valid,
  output logic [7:0] sample_code,
  output logic mission_active
);
  int q[$];
  int gap = 0;
  logic slow = 1'b0;
  initial begin
    sample_valid = 1'b0;
    sample_code = 8'hA5;
    mission_active = 1'b0;
  end
  // ************************************************************
  // requests from the bench
  // ************************************************************
  task automatic put(input int t);
    q.push_back(t < 0 ? 0 : (t > 255 ? 255 : t));
  endtask : put
  task automatic mission(input logic m);
    @(posedge aclk);
    mission_active <= m;
  endtask : mission
  // ************************************************************
  // result pulses
  // ************************************************************
  // code scrambled between pulses: a stale code must never look valid
  always @(posedge aclk) begin
    if (!aresetn) begin
      sample_valid <= 1'b0;
      gap <= 0;
    end else if (gap == 0 && q.size() != 0) begin
      sample_valid <= 1'b1;
      sample_code <= 8'(q.pop_front());
      gap <= slow ? 3 : 0;
    end else begin
      sample_valid <= 1'b0;
      sample_code <= ~sample_code;
      if (gap != 0) gap <= gap - 1;
    end
  end
endmodule : tlh_sensor_model
`default_nettype wire
